// ### include/lf_meter_regs.svh
// Timing, threshold and tag constants of the light frequency/period meter
`ifndef LF_METER_REGS_SVH
`define LF_METER_REGS_SVH

// System clock rate in hertz
`define LF_CLK_HZ 100000000
// Gathering window length in seconds
`define LF_GATE_TIME_S 1
// Gathering window in clock cycles
`define LF_GATE_CYCLES (`LF_GATE_TIME_S * `LF_CLK_HZ)
// Clock cycles per microsecond tick
`define LF_US_CYCLES (`LF_CLK_HZ / 1000000)
// Gathering window in microseconds
`define LF_GATE_US (`LF_GATE_TIME_S * 1000000)
// Dark timeout in seconds, and in microseconds
`define LF_TIMEOUT_S 300
`define LF_TIMEOUT_US (`LF_TIMEOUT_S * 1000000)
// Temperature sample rate in hertz and cycles per sample
`define LF_TEMP_RATE_HZ 60
`define LF_TEMP_TICK_CYCLES (`LF_CLK_HZ / `LF_TEMP_RATE_HZ)
// Temperature samples per average (power of two)
`define LF_TEMP_SAMPLES 256
`define LF_TEMP_SHIFT 8
// Crossover frequencies in hertz
`define LF_XOVER_STD_HZ 354
`define LF_XOVER_IDEAL_HZ 679
// Rolling average depth
`define LF_AVG_DEPTH 8
// Status suffix characters
`define LF_TAG_FREQ 8'h46
`define LF_TAG_PERIOD 8'h50
`define LF_TAG_STALE 8'h53
`define LF_TAG_NONE 8'h00
// Request queue depth
`define LF_QUEUE_DEPTH 4

`endif

// ### include/lf_pkg.sv
// Types shared by the light frequency/period meter
`default_nettype none
package lf_pkg;

  // Period measurement states, Gray coded
  typedef enum logic [1:0] {
    LF_PER_IDLE = 2'b00,
    LF_PER_RUN = 2'b01
  } lf_per_state_t;

  // Host request kinds
  typedef enum logic {
    LF_CMD_RAW = 1'b0,
    LF_CMD_TAGGED = 1'b1
  } lf_cmd_t;

endpackage
`default_nettype wire

// ### rtl/lf_avg8.sv
// Rolling average over a small ring of past readings
`timescale 1ns/1ps
`default_nettype none
module lf_avg8 #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] avg
);
  import lf_pkg::*;

  localparam int SHIFT = $clog2(DEPTH);
  localparam int SW = WIDTH + SHIFT;

  logic [WIDTH-1:0] ring [DEPTH];   // Past readings
  logic [SHIFT-1:0] ptr;            // Oldest entry
  logic [SW-1:0] sum;               // Running total of the ring
  logic [SHIFT-1:0] next_ptr;
  logic [SW-1:0] next_sum;
  logic [WIDTH-1:0] next_avg;

  // ********************************
  // Next values
  // ********************************
  // Swap the oldest entry for the new one; the ring starts at zero, so
  // a step change reaches full value only after DEPTH readings
  always_comb begin
    next_ptr = ptr;
    next_sum = sum;
    next_avg = avg;
    if (push) begin
      next_ptr = ptr + 1'b1;
      next_sum = sum + SW'(din) - SW'(ring[ptr]);
      next_avg = WIDTH'(next_sum >> SHIFT);
    end
  end

  // Register the ring and the total
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr <= '0;
      sum <= '0;
      avg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        ring[i] <= '0;
      end
    end else if (clkEn) begin
      ptr <= next_ptr;
      sum <= next_sum;
      avg <= next_avg;
      if (push) begin
        ring[ptr] <= din;
      end
    end
  end
endmodule // lf_avg8
`default_nettype wire

// ### rtl/lf_meter.sv
// Light-to-frequency sensor readout with frequency and period modes
`timescale 1ns/1ps
`default_nettype none
`include "lf_meter_regs.svh"

// Summary of operation
// - Each result gathers light at least one second
// - Frequency mode counts edges per one-second window
// - Period mode times sensor periods in microseconds
// - Crossover 354Hz, or 679Hz with ideal option
// - Period measurement gives up after 300 seconds
// - Frequency path counts inputs up to 500kHz
// - Readings pass through eight-entry rolling average
// - Reading holds until a new measurement completes
// - Latest results stored and returned on request
// - Raw command returns frequency and period together
// - Select period or frequency; temperature average sent beside it for outside compensation
// - Tagged command appends F, P or S
// - Stale when nothing new since previous request
// - Requests queue and are served independently
// - Temperature averages 256 samples at 60Hz
module lf_meter #(
  parameter int GATE_CYCLES = `LF_GATE_CYCLES,
  parameter int TIMEOUT_US = `LF_TIMEOUT_US,
  parameter int TEMP_TICK_CYCLES = `LF_TEMP_TICK_CYCLES,
  parameter int QDEPTH = `LF_QUEUE_DEPTH,
  parameter int TEMP_W = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic sensorIn,
  input wire logic idealCrossover,
  input wire logic [TEMP_W-1:0] tempIn,
  input wire logic reqValid,
  input wire lf_pkg::lf_cmd_t reqCmd,
  output logic reqReady,
  output logic rspValid,
  output logic [31:0] rspFreq,
  output logic [31:0] rspPeriod,
  output logic [31:0] rspSelected,
  output logic rspPeriodMode,
  output logic [7:0] rspTag,
  output logic [TEMP_W-1:0] tempAvg
);
  import lf_pkg::*;

  localparam int QW = $clog2(QDEPTH);

  // ********************************
  // Input synchronisers
  // ********************************
  logic sensMeta, sensSync, sensPrev;  // Sensor chain
  logic xoMeta, xoSync;                // Crossover option chain
  logic sensRise;                      // Rising edge of the sensor

  // Two stages before use, third for the edge detector
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sensMeta <= 1'b0;
      sensSync <= 1'b0;
      sensPrev <= 1'b0;
      xoMeta <= 1'b0;
      xoSync <= 1'b0;
    end else if (clkEn) begin
      sensMeta <= sensorIn;
      sensSync <= sensMeta;
      sensPrev <= sensSync;
      xoMeta <= idealCrossover;
      xoSync <= xoMeta;
    end
  end
  // Only rising edges count; a 500kHz wave is far below clk/4
  assign sensRise = sensSync & ~sensPrev;

  // ********************************
  // Frequency mode and microsecond tick
  // ********************************
  logic [31:0] gateCnt, next_gateCnt;    // Cycles into the window
  logic [31:0] edgeCnt, next_edgeCnt;    // Edges in the window
  logic [31:0] freqRaw, next_freqRaw;    // Last window result
  logic freqDone, next_freqDone;         // Window closed pulse
  logic [6:0] usCnt, next_usCnt;         // Microsecond prescaler
  logic usTick;

  assign usTick = (usCnt == 7'(`LF_US_CYCLES - 1));

  // Back-to-back one-second windows; edge count is hertz directly
  always_comb begin
    next_gateCnt = gateCnt + 32'h1;
    next_edgeCnt = edgeCnt + (sensRise ? 32'h1 : 32'h0);
    next_freqRaw = freqRaw;
    next_freqDone = 1'b0;
    next_usCnt = usTick ? 7'h0 : usCnt + 7'h1;
    if (gateCnt == 32'(GATE_CYCLES - 1)) begin
      // An edge in the last cycle closes this window; the next starts
      // empty, so no edge is counted in two windows
      next_freqRaw = next_edgeCnt;
      next_gateCnt = 32'h0;
      next_edgeCnt = 32'h0;
      next_freqDone = 1'b1;
    end
  end

  // Register the frequency counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gateCnt <= 32'h0;
      edgeCnt <= 32'h0;
      freqRaw <= 32'h0;
      freqDone <= 1'b0;
      usCnt <= 7'h0;
    end else if (clkEn) begin
      gateCnt <= next_gateCnt;
      edgeCnt <= next_edgeCnt;
      freqRaw <= next_freqRaw;
      freqDone <= next_freqDone;
      usCnt <= next_usCnt;
    end
  end

  // ********************************
  // Period mode
  // ********************************
  lf_per_state_t perState, next_perState;
  logic [31:0] elapsedUs, next_elapsedUs;  // Time since first edge
  logic [23:0] perN, next_perN;            // Whole periods seen
  logic [31:0] perRaw, next_perRaw;        // Last period in us
  logic perDone, next_perDone;             // Period result pulse
  logic [23:0] nPlus;

  // Position of the single set bit of a power of two
  function automatic logic [31:0] lf_shift_of(input logic [23:0] v);
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 24; i++) begin
      if (v[i]) begin
        s = 32'(i);
      end
    end
    return s;
  endfunction

  assign nPlus = perN + 24'h1;

  // The sensor gates a microsecond counter; periods are taken in
  // power-of-two groups spanning at least one second so the mean is
  // a shift, not a divider
  always_comb begin
    next_perState = perState;
    next_elapsedUs = elapsedUs + (usTick ? 32'h1 : 32'h0);
    next_perN = perN;
    next_perRaw = perRaw;
    next_perDone = 1'b0;
    case (perState)
      LF_PER_IDLE: begin
        if (sensRise) begin
          next_perState = LF_PER_RUN;
          next_elapsedUs = 32'h0;
          next_perN = 24'h0;
        end
      end
      LF_PER_RUN: begin
        if (sensRise) begin
          next_perN = nPlus;
          if (elapsedUs >= 32'(`LF_GATE_US) &&
              (nPlus & perN) == 24'h0) begin
            next_perRaw = elapsedUs >> lf_shift_of(nPlus);
            next_perDone = 1'b1;
            next_elapsedUs = 32'h0;
            next_perN = 24'h0;
          end
        end
      end
      default: begin
        next_perState = LF_PER_IDLE;
      end
    endcase
    // Absolute darkness: report the timeout as the dark period
    if (!sensRise && elapsedUs >= 32'(TIMEOUT_US)) begin
      next_perState = LF_PER_IDLE;
      next_perRaw = 32'(TIMEOUT_US);
      next_perDone = 1'b1;
      next_elapsedUs = 32'h0;
      next_perN = 24'h0;
    end
  end

  // Register the period state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      perState <= LF_PER_IDLE;
      elapsedUs <= 32'h0;
      perN <= 24'h0;
      perRaw <= 32'h0;
      perDone <= 1'b0;
    end else if (clkEn) begin
      perState <= next_perState;
      elapsedUs <= next_elapsedUs;
      perN <= next_perN;
      perRaw <= next_perRaw;
      perDone <= next_perDone;
    end
  end

  // ********************************
  // Rolling averages and mode choice
  // ********************************
  logic [31:0] freqAvg, perAvg;  // Averaged results, held between pushes

  // Each average moves only on completion; dark gaps hold the period one until timeout, frequency windows push zero
  lf_avg8 #(.WIDTH(32), .DEPTH(`LF_AVG_DEPTH)) uFreqAvg (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .push(freqDone),
    .din(freqRaw),
    .avg(freqAvg)
  );
  lf_avg8 #(.WIDTH(32), .DEPTH(`LF_AVG_DEPTH)) uPerAvg (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .push(perDone),
    .din(perRaw),
    .avg(perAvg)
  );

  logic usePeriod;  // Below crossover the period result is finer
  assign usePeriod = freqAvg < (xoSync ? 32'(`LF_XOVER_IDEAL_HZ)
                                       : 32'(`LF_XOVER_STD_HZ));

  // ********************************
  // Temperature average
  // ********************************
  logic [31:0] tTick, next_tTick;          // Cycles into the sample interval
  logic [8:0] tCnt, next_tCnt;             // Samples taken
  logic [TEMP_W+7:0] tSum, next_tSum;      // Sample total
  logic [TEMP_W-1:0] next_tempAvg;

  // 256 samples at 60Hz, about 4.3s per new compensation value
  always_comb begin
    next_tTick = tTick + 32'h1;
    next_tCnt = tCnt;
    next_tSum = tSum;
    next_tempAvg = tempAvg;
    if (tTick == 32'(TEMP_TICK_CYCLES - 1)) begin
      next_tTick = 32'h0;
      next_tSum = tSum + (TEMP_W+8)'(tempIn);
      next_tCnt = tCnt + 9'h1;
      if (tCnt == 9'(`LF_TEMP_SAMPLES - 1)) begin
        next_tempAvg = TEMP_W'(next_tSum >> `LF_TEMP_SHIFT);
        next_tSum = '0;
        next_tCnt = 9'h0;
      end
    end
  end

  // Register the temperature averager
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tTick <= 32'h0;
      tCnt <= 9'h0;
      tSum <= '0;
      tempAvg <= '0;
    end else if (clkEn) begin
      tTick <= next_tTick;
      tCnt <= next_tCnt;
      tSum <= next_tSum;
      tempAvg <= next_tempAvg;
    end
  end

  // ********************************
  // Request queue and answers
  // ********************************
  lf_cmd_t queue [QDEPTH];              // Pending request kinds
  logic [QW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [QW:0] qCount, next_qCount;
  logic push, pop;
  logic fresh, next_fresh;              // New result since last report
  logic next_reqReady, next_rspValid, next_rspPeriodMode;
  logic [31:0] next_rspFreq, next_rspPeriod, next_rspSelected;
  logic [7:0] next_rspTag;

  // Host requests wait here while measurement carries on
  assign push = reqValid && reqReady;
  assign pop = qCount != '0;

  // Serve one queued request per cycle from the stored results
  always_comb begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_qCount = qCount + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    next_reqReady = next_qCount < (QW+1)'(QDEPTH);
    next_rspValid = pop;
    next_rspFreq = rspFreq;
    next_rspPeriod = rspPeriod;
    next_rspSelected = rspSelected;
    next_rspPeriodMode = rspPeriodMode;
    next_rspTag = rspTag;
    next_fresh = fresh;
    if (pop) begin
      next_rspFreq = freqAvg;
      next_rspPeriod = perAvg;
      // Compensation itself is outside; tempAvg travels beside it
      next_rspSelected = usePeriod ? perAvg : freqAvg;
      next_rspPeriodMode = usePeriod;
      next_rspTag = `LF_TAG_NONE;
      if (queue[rdPtr] == LF_CMD_TAGGED) begin
        if (!fresh) begin
          next_rspTag = `LF_TAG_STALE;
        end else if (usePeriod) begin
          next_rspTag = `LF_TAG_PERIOD;
        end else begin
          next_rspTag = `LF_TAG_FREQ;
        end
      end
      next_fresh = 1'b0;
    end
    // A completion in the reporting cycle still counts as fresh
    if (freqDone || perDone) begin
      next_fresh = 1'b1;
    end
  end

  // Register the queue and answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      qCount <= '0;
      fresh <= 1'b0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspFreq <= 32'h0;
      rspPeriod <= 32'h0;
      rspSelected <= 32'h0;
      rspPeriodMode <= 1'b0;
      rspTag <= 8'h00;
      for (int i = 0; i < QDEPTH; i++) begin
        queue[i] <= LF_CMD_RAW;
      end
    end else if (clkEn) begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      qCount <= next_qCount;
      fresh <= next_fresh;
      reqReady <= next_reqReady;
      rspValid <= next_rspValid;
      rspFreq <= next_rspFreq;
      rspPeriod <= next_rspPeriod;
      rspSelected <= next_rspSelected;
      rspPeriodMode <= next_rspPeriodMode;
      rspTag <= next_rspTag;
      if (push) begin
        queue[wrPtr] <= reqCmd;
      end
    end
  end
endmodule // lf_meter
`default_nettype wire

// ### tb/lf_meter_asserts.sv
// Port-level checker of the light meter's request and result side
`timescale 1ns/1ps
`default_nettype none
module lf_meter_asserts #(
  parameter int QDEPTH = 4 // Request queue depth of the meter
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [31:0] rspFreq,
  input wire logic [31:0] rspPeriod,
  input wire logic [31:0] rspSelected,
  input wire logic rspPeriodMode,
  input wire logic [7:0] rspTag
);
  // ****************
  // Outstanding requests
  // ****************
  localparam int MAXWAIT = QDEPTH + 1; // Longest wait behind a full queue
  logic take; // Request taken at this edge
  logic [3:0] pend; // Taken but not yet answered
  logic [3:0] next_pend;
  assign take = clkEn && reqValid && reqReady;
  // Answer seen one edge after it is issued, so pend lags the queue
  always_comb begin
    next_pend = pend + {3'h0, take} - {3'h0, clkEn && rspValid};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      pend <= 4'h0;
    else
      pend <= next_pend;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************
  // Properties
  // ****************
  AST_TAKE_ANSWER: assert property (take |-> ##[2:MAXWAIT] rspValid)
    else $error("taken request not answered in time");
  AST_FIRST_ANSWER: assert property (
    (take && pend == 4'h0) |=> !rspValid ##1 rspValid)
    else $error("idle request answer not two cycles later");
  AST_NO_SPURIOUS: assert property (rspValid |-> pend != 4'h0)
    else $error("answer without a request");
  AST_READY_IDLE: assert property ((pend == 4'h0) [*3] |-> reqReady)
    else $error("ready low with empty queue");
  AST_HOLD_DATA: assert property (!rspValid |-> $stable(rspFreq) &&
    $stable(rspPeriod) && $stable(rspSelected) && $stable(rspTag) &&
    $stable(rspPeriodMode))
    else $error("result changed without an answer");
  AST_SELECT: assert property (rspValid |->
    rspSelected == (rspPeriodMode ? rspPeriod : rspFreq))
    else $error("selected result does not follow mode");
  AST_TAG_SET: assert property (rspValid |->
    rspTag inside {8'h00, 8'h46, 8'h50, 8'h53})
    else $error("unknown status suffix");
  AST_TAG_MODE: assert property ((rspValid &&
    rspTag inside {8'h46, 8'h50}) |-> rspPeriodMode == (rspTag == 8'h50))
    else $error("fresh suffix disagrees with mode");
endmodule // lf_meter_asserts

bind lf_meter lf_meter_asserts #(.QDEPTH(QDEPTH)) lf_meter_asserts_i (
  .clk(clk), .resetn(resetn), .clkEn(clkEn), .reqValid(reqValid),
  .reqReady(reqReady), .rspValid(rspValid), .rspFreq(rspFreq),
  .rspPeriod(rspPeriod), .rspSelected(rspSelected),
  .rspPeriodMode(rspPeriodMode), .rspTag(rspTag));
`default_nettype wire

// ### tb/lf_sensor_model.sv
// Square-wave model of the light-to-frequency sensor
`timescale 1ns/1ps
`default_nettype none
module lf_sensor_model #(
  parameter int HALF = 2 // Clock cycles per half wave
) (
  input wire logic clk,
  input wire logic run,
  output logic wave
);
  // ****************
  // Wave generator
  // ****************
  logic [7:0] count = 8'h00; // Cycles into the current half wave
  initial wave = 1'b0;
  // Dark sensor rests low, so no stray edge reaches the meter
  always @(posedge clk) begin
    if (!run) begin
      wave <= 1'b0;
      count <= 8'h00;
    end else if (count == 8'(HALF - 1)) begin
      wave <= ~wave; // Fastest scaled rate of a bright sky
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule // lf_sensor_model
`default_nettype wire

// ### tb/lf_meter_bench.sv
// Self-checking bench of the light meter
`timescale 1ns/1ps
`default_nettype none
module lf_meter_bench;
  import lf_pkg::*;
  // ****************
  // Setup
  // ****************
  localparam int GATE = 2000; // Short window keeps the run brief
  localparam int TOUT = 160; // Dark timeout in microseconds
  localparam int CEIL = 60000; // Hang limit in cycles
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b1; // Sensor lit
  logic idealCrossover = 1'b0;
  logic clkEn = 1'b1; // Dropped to freeze the meter
  logic [11:0] tempIn = 12'h5a5; // Steps between two values about its mean
  logic reqValid = 1'b0;
  lf_cmd_t reqCmd = LF_CMD_RAW;
  logic sensorIn, reqReady, rspValid, rspPeriodMode;
  logic [31:0] rspFreq, rspPeriod, rspSelected;
  logic [7:0] rspTag;
  logic [11:0] tempAvg;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  lf_sensor_model #(.HALF(2)) lf_sensor_model_i (.clk(clk), .run(run),
    .wave(sensorIn));
  lf_meter #(.GATE_CYCLES(GATE), .TIMEOUT_US(TOUT), .TEMP_TICK_CYCLES(4))
    lf_meter_i (.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .sensorIn(sensorIn), .idealCrossover(idealCrossover),
    .tempIn(tempIn), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqReady(reqReady), .rspValid(rspValid), .rspFreq(rspFreq),
    .rspPeriod(rspPeriod), .rspSelected(rspSelected),
    .rspPeriodMode(rspPeriodMode), .rspTag(rspTag), .tempAvg(tempAvg));
  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until taken, then answer awaited
  task automatic ask(input lf_cmd_t c);
    int n = 0;
    reqValid <= 1'b1;
    reqCmd <= c;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < 8);
    check(rspValid, 1'b1);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_stale(); // Nothing measured yet
    ask(LF_CMD_RAW);
    check(rspTag, 8'h00);
    ask(LF_CMD_TAGGED);
    check(rspTag, 8'h53);
  endtask
  task automatic t_freq(); // Bright light, standard crossover
    tick(5 * GATE);
    ask(LF_CMD_RAW);
    check(rspFreq > 0 && rspFreq < 32'h1f4, 1'b1);
    tick(5 * GATE);
    ask(LF_CMD_TAGGED);
    check(rspFreq, 32'h1f4);
    check(rspTag, 8'h46);
    check(rspPeriodMode, 1'b0);
    check(rspSelected, 32'h1f4);
    check(tempAvg, 12'h5a6);
    ask(LF_CMD_TAGGED);
    check(rspTag, 8'h53);
    tick(GATE);
    ask(LF_CMD_TAGGED);
    check(rspTag, 8'h46);
  endtask
  task automatic t_ideal(); // Same light under the higher crossover
    idealCrossover <= 1'b1;
    tick(GATE);
    ask(LF_CMD_TAGGED);
    check(rspPeriodMode, 1'b1);
    check(rspTag, 8'h50);
    check(rspSelected, TOUT / 8);
    idealCrossover <= 1'b0;
  endtask
  task automatic t_burst(); // Four requests back to back
    int takes = 0;
    int answers = 0;
    reqValid <= 1'b1;
    reqCmd <= LF_CMD_RAW;
    repeat (12) begin
      @(posedge clk);
      if (reqValid && reqReady === 1'b1)
        takes++;
      if (rspValid === 1'b1)
        answers++;
      if (takes == 4)
        reqValid <= 1'b0;
    end
    check(answers, 32'h4);
  endtask
  task automatic t_dark(); // One edge, then darkness until timeout
    run <= 1'b0;
    resetn <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(4);
    run <= 1'b1;
    tick(3);
    run <= 1'b0;
    tick(50 * TOUT);
    ask(LF_CMD_TAGGED);
    check(rspPeriod, 32'h0);
    check(rspPeriodMode, 1'b1);
    tick(60 * TOUT);
    ask(LF_CMD_TAGGED);
    check(rspPeriod, TOUT / 8);
    check(rspTag, 8'h50);
  endtask
  // Enable low holds every flip-flop; a request waits through it and
  // no window may close meanwhile, so the answer must be stale
  task automatic t_freeze();
    int answers = 0;
    clkEn <= 1'b0;
    reqValid <= 1'b1;
    reqCmd <= LF_CMD_TAGGED;
    repeat (GATE) begin
      @(posedge clk);
      if (rspValid === 1'b1)
        answers++;
    end
    check(answers, 32'h0);
    clkEn <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    tick(2);
    check(rspValid, 1'b1);
    check(rspTag, 8'h53);
  endtask
  // ****************
  // Sequence and hang guard
  // ****************
  // Temperature flips bit 1 every four cycles, so successive samples
  // alternate and only a true mean gives the value in between
  always @(posedge clk) begin
    cycles++;
    tempIn <= 12'h5a5 ^ {10'h0, cycles[2], 1'b0};
    if (cycles == CEIL) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    tick(8);
    resetn <= 1'b1;
    tick(2);
    t_stale();
    t_freq();
    t_ideal();
    t_burst();
    t_dark();
    t_freeze();
    end_of_test();
  end
endmodule // lf_meter_bench
`default_nettype wire
